/* File: core/msi_and_power_mgmt_regs.sv */
// Message interrupt and power management configuration registers
`timescale 1ns/1ns
`include "msi_pm_regs.svh"

module msi_and_power_mgmt_regs (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire logic                   warm_rst,
   input  wire logic                   hotplug_strap_config,
   input  wire logic                   message_interrupt_enable,
   input  wire msi_pm_pkg::cfg_req_t   cfg_req,
   output logic [31:0]                 cfg_rdata,
   output logic                        cfg_ack,
   input  wire logic                   hotplug_request,
   output msi_pm_pkg::msg_write_t      msg_write,
   output logic                        wake_message,
   output logic [1:0]                  power_state_field
);
   import msi_pm_pkg::*;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Byte-lane merge of a write into an old value
   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_be

   // Write to one byte lane of the status/control word
   function automatic logic ctl_lane_write(input cfg_req_t req,
                                           input int       lane);
      return req.wr && (req.addr == `OFF_PM_STATUS_CONTROL) && req.be[lane];
   endfunction : ctl_lane_write

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [31:0]  addr_low_q,   addr_low_d;    // Low message address
   logic [31:0]  addr_high_q,  addr_high_d;   // High message address
   logic [15:0]  msg_data_q,   msg_data_d;    // Message data
   logic         wake_sts_q,   wake_sts_d;    // Sticky wake status
   logic         wake_en_q,    wake_en_d;     // Sticky wake enable
   power_state_t pstate_q,     pstate_d;      // Power state
   logic         strap_q,      strap_d;       // Captured hotplug strap
   logic [31:0]  rdata_q,      rdata_d;       // Read data
   logic         ack_q,        ack_d;         // Access done
   msg_write_t   msg_q,        msg_d;         // Interrupt write
   logic         wake_q,       wake_d;        // Wake message pulse
   logic [31:0]  wmerge;                      // Merged write word
   logic [31:0]  cap_word;                    // Capability register value
   logic [31:0]  ctl_word;                    // Status/control value
   logic         wake_req;                    // Qualified wake request
   logic         msi_req;                     // Qualified interrupt write request
   logic         ctl_wr_hi;                   // Write to status/control byte 1
   logic         ctl_wr_lo;                   // Write to status/control byte 0

   // ----------------------------------------------------------------------
   // Read views of the capability and status/control registers
   // ----------------------------------------------------------------------
   // Capability word assembly
   always_comb begin
      cap_word          = 32'h00000000;
      cap_word[31:27]   = `WAKE_STATE_SUPPORT_VAL;
      cap_word[18:16]   = `PM_VERSION_VAL;
      cap_word[15:8]    = strap_q ? `NEXT_CAP_HOTPLUG_ON
                                  : `NEXT_CAP_HOTPLUG_OFF;
      cap_word[7:0]     = `CAPABILITY_ID_VAL;
   end

   // Status/control word assembly; data fields stay zero
   always_comb begin
      ctl_word                   = 32'h00000000;
      ctl_word[`WAKE_STATUS_BIT] = wake_sts_q;
      ctl_word[`WAKE_ENABLE_BIT] = wake_en_q;
      ctl_word[1:0]              = pstate_q;
   end

   // ----------------------------------------------------------------------
   // Request qualification
   // ----------------------------------------------------------------------
   // Wake request only from D3hot
   assign wake_req = hotplug_request && (pstate_q == PS_D3HOT);

   // Interrupt write request; D3hot or a clear enable blocks it
   assign msi_req = hotplug_request && message_interrupt_enable
                    && (pstate_q == PS_D0);

   // Byte-lane strobes of a write to the status/control word
   assign ctl_wr_hi = ctl_lane_write(cfg_req, 1);
   assign ctl_wr_lo = ctl_lane_write(cfg_req, 0);

   // ----------------------------------------------------------------------
   // Message registers
   // ----------------------------------------------------------------------
   // Next address and data words; writes merge by byte lane
   always_comb begin
      addr_low_d  = addr_low_q;                             // Hold by default
      addr_high_d = addr_high_q;                            // Hold by default
      msg_data_d  = msg_data_q;                             // Hold by default
      wmerge      = 32'h00000000;                           // No merge by default
      // Only writes change the message words
      if (cfg_req.wr) begin
         case (cfg_req.addr)
            `OFF_MSI_ADDRESS_LOW: begin
               // Low address word; the two low bits stay zero
               wmerge     = merge_be(addr_low_q, cfg_req.wdata, cfg_req.be);
               addr_low_d = wmerge & `ADDR_LOW_MASK;
            end
            `OFF_MSI_ADDRESS_HIGH: begin
               // High address word; also dword aligned
               wmerge      = merge_be(addr_high_q, cfg_req.wdata, cfg_req.be);
               addr_high_d = wmerge & `ADDR_LOW_MASK;
            end
            `OFF_MSI_MESSAGE_DATA: begin
               // Only the low half-word is storage
               wmerge     = merge_be({16'h0000, msg_data_q}, cfg_req.wdata, cfg_req.be);
               msg_data_d = wmerge[15:0];
            end
            default: begin
               // Other offsets hold no message state
               wmerge = 32'h00000000;
            end
         endcase
      end
   end

   // Message words; cleared by either reset
   always_ff @(posedge ref_clk) begin
      if (rst || warm_rst) begin
         addr_low_q  <= `ADDR_RESET_VAL;
         addr_high_q <= `ADDR_RESET_VAL;
         msg_data_q  <= `MSG_DATA_RESET_VAL;
      end else begin
         // Take the next values
         addr_low_q  <= addr_low_d;
         addr_high_q <= addr_high_d;
         msg_data_q  <= msg_data_d;
      end
   end

   // ----------------------------------------------------------------------
   // Sticky wake status and enable
   // ----------------------------------------------------------------------
   // Next values; hardware set wins over a same-cycle write-one clear
   always_comb begin
      wake_sts_d = wake_sts_q;                             // Hold by default
      wake_en_d  = wake_en_q;                              // Hold by default
      // Both bits live in byte lane one
      if (ctl_wr_hi) begin
         wake_en_d = cfg_req.wdata[`WAKE_ENABLE_BIT];
         if (cfg_req.wdata[`WAKE_STATUS_BIT]) begin
            wake_sts_d = 1'b0;                             // Write one clears
         end
      end
      // A wake request in the same cycle overrides the clear
      if (wake_req) begin
         wake_sts_d = 1'b1;                                // Set whatever the enable
      end
   end

   // Sticky bits survive warm reset; only the full reset clears them
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wake_sts_q <= 1'b0;
         wake_en_q  <= 1'b0;
      end else begin
         // Take the next values
         wake_sts_q <= wake_sts_d;
         wake_en_q  <= wake_en_d;
      end
   end

   // ----------------------------------------------------------------------
   // Power state and strap copy
   // ----------------------------------------------------------------------
   // Next values; reserved codes are acknowledged but dropped
   always_comb begin
      pstate_d = pstate_q;                                 // Hold by default
      strap_d  = hotplug_strap_config;                     // Follow the strap pin
      // Only byte lane zero carries the state field
      if (ctl_wr_lo) begin
         case (cfg_req.wdata[1:0])
            `PSTATE_D0: begin
               pstate_d = PS_D0;
            end
            `PSTATE_D3HOT: begin
               pstate_d = PS_D3HOT;
            end
            default: begin
               pstate_d = pstate_q;                        // Reserved code
            end
         endcase
      end
   end

   // Power state and strap copy; cleared by either reset
   always_ff @(posedge ref_clk) begin
      if (rst || warm_rst) begin
         pstate_q <= PS_D0;
         strap_q  <= 1'b0;                                 // Reloads one edge later
      end else begin
         // Take the next values
         pstate_q <= pstate_d;
         strap_q  <= strap_d;
      end
   end

   // ----------------------------------------------------------------------
   // Configuration response
   // ----------------------------------------------------------------------
   // Every access is acknowledged; read data holds until the next read
   always_comb begin
      ack_d   = cfg_req.rd || cfg_req.wr;
      rdata_d = rdata_q;                                   // Hold by default
      // Select the addressed word
      if (cfg_req.rd) begin
         case (cfg_req.addr)
            `OFF_MSI_ADDRESS_LOW:   rdata_d = addr_low_q;
            `OFF_MSI_ADDRESS_HIGH:  rdata_d = addr_high_q;
            `OFF_MSI_MESSAGE_DATA:  rdata_d = {16'h0000, msg_data_q};
            `OFF_PM_CAPABILITY:     rdata_d = cap_word;
            `OFF_PM_STATUS_CONTROL: rdata_d = ctl_word;
            default:                rdata_d = 32'h00000000; // Unmapped reads give zero
         endcase
      end
   end

   // Response flops; cleared by either reset
   always_ff @(posedge ref_clk) begin
      if (rst || warm_rst) begin
         rdata_q <= 32'h00000000;
         ack_q   <= 1'b0;
      end else begin
         // Take the next values
         rdata_q <= rdata_d;
         ack_q   <= ack_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outgoing messages
   // ----------------------------------------------------------------------
   // At most one interrupt write or one wake message per request cycle
   always_comb begin
      msg_d  = '0;                                         // Idle by default
      wake_d = 1'b0;                                       // Idle by default
      // D3hot requests take the wake path, D0 requests the interrupt path
      if (wake_req) begin
         wake_d = wake_en_q;                               // Enable gates it
      end else if (msi_req) begin
         msg_d.valid  = 1'b1;
         msg_d.addr   = {addr_high_q, addr_low_q};
         msg_d.addr64 = (addr_high_q != 32'h00000000);
         msg_d.data   = {16'h0000, msg_data_q};
      end
   end

   // Message flops; cleared by either reset
   always_ff @(posedge ref_clk) begin
      if (rst || warm_rst) begin
         msg_q  <= '0;
         wake_q <= 1'b0;
      end else begin
         // Take the next values
         msg_q  <= msg_d;
         wake_q <= wake_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Outputs straight from flops
   assign cfg_rdata         = rdata_q;
   assign cfg_ack           = ack_q;
   assign msg_write         = msg_q;
   assign wake_message      = wake_q;
   assign power_state_field = pstate_q;

endmodule : msi_and_power_mgmt_regs

/* File: core/msi_pm_regs.svh */
// Offsets, field positions, reset values and constants of the message and power registers
`ifndef MSI_PM_REGS_SVH
`define MSI_PM_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFF_MSI_ADDRESS_LOW    8'h60
`define OFF_MSI_ADDRESS_HIGH   8'h64
`define OFF_MSI_MESSAGE_DATA   8'h68
`define OFF_PM_CAPABILITY      8'h6C
`define OFF_PM_STATUS_CONTROL  8'h70

// ----------------------------------------------------------------------
// Capability field values
// ----------------------------------------------------------------------
`define WAKE_STATE_SUPPORT_VAL 5'h19
`define PM_VERSION_VAL         3'h2
`define NEXT_CAP_HOTPLUG_ON    8'h78
`define NEXT_CAP_HOTPLUG_OFF   8'hD8
`define CAPABILITY_ID_VAL      8'h01
`define HOTPLUG_STRAP_BIT      3

// ----------------------------------------------------------------------
// Status / control field positions
// ----------------------------------------------------------------------
`define WAKE_STATUS_BIT        15
`define WAKE_ENABLE_BIT        8
`define PSTATE_D0              2'h0
`define PSTATE_D3HOT           2'h3
`define ADDR_LOW_MASK          32'hFFFFFFFC

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ADDR_RESET_VAL         32'h00000000
`define MSG_DATA_RESET_VAL     16'h0000

`endif

/* File: core/msi_pm_pkg.sv */
// Types shared by the message and power register bank
package msi_pm_pkg;

   // Configuration access request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } cfg_req_t;

   // Interrupt memory write request
   typedef struct packed {
      logic        valid;
      logic        addr64;
      logic [63:0] addr;
      logic [31:0] data;
   } msg_write_t;

   // Power state encoding
   typedef enum logic [1:0] {
      PS_D0    = 2'b00,
      PS_R1    = 2'b01,
      PS_R2    = 2'b10,
      PS_D3HOT = 2'b11
   } power_state_t;

endpackage : msi_pm_pkg

/* File: testbench/msi_pm_properties.sv */
// Port-level checks for the message and power register bank
`timescale 1ns/1ns
module msi_pm_properties (
   input wire logic                   ref_clk,
   input wire logic                   rst,
   input wire logic                   warm_rst,
   input wire logic                   hotplug_strap_config,
   input wire logic                   message_interrupt_enable,
   input wire msi_pm_pkg::cfg_req_t   cfg_req,
   input wire logic [31:0]            cfg_rdata,
   input wire logic                   cfg_ack,
   input wire logic                   hotplug_request,
   input wire msi_pm_pkg::msg_write_t msg_write,
   input wire logic                   wake_message,
   input wire logic [1:0]             power_state_field
);
   import msi_pm_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst || warm_rst);
   logic rd_cap; // Read of the capability word
   assign rd_cap = cfg_req.rd && cfg_req.addr == 8'h6C;
   cap_fixed_a: assert property (rd_cap |=>
      cfg_rdata[31:16] == 16'hC802 && cfg_rdata[7:0] == 8'h01) else $error("cap fields");
   next_ptr_a: assert property (rd_cap && $stable(hotplug_strap_config) |=>
      cfg_rdata[15:8] == ($past(hotplug_strap_config) ? 8'h78 : 8'hD8)) else $error("next ptr");
   addr_low_a: assert property (cfg_req.rd && cfg_req.addr inside {8'h60, 8'h64}
      |=> cfg_rdata[1:0] == 2'h0) else $error("address low bits");
   pm_zero_a: assert property (cfg_req.rd && cfg_req.addr == 8'h70 |=>
      cfg_rdata[31:16] == 16'h0 && cfg_rdata[14:9] == 6'h0) else $error("data fields");
   state_legal_a: assert property (power_state_field inside {2'h0, 2'h3})
      else $error("power state code");
   state_keep_a: assert property (cfg_req.wr && cfg_req.addr == 8'h70 && cfg_req.be[0] &&
      cfg_req.wdata[1:0] inside {2'h1, 2'h2} |=> $stable(power_state_field)) else $error("state");
   access_ack_a: assert property (cfg_req.rd || cfg_req.wr |=> cfg_ack)
      else $error("no ack");
   msi_gate_a: assert property (msg_write.valid |-> $past(message_interrupt_enable) &&
      $past(power_state_field) == 2'h0) else $error("message write not allowed");
   msi_fire_a: assert property (hotplug_request && message_interrupt_enable &&
      power_state_field == 2'h0 |=> msg_write.valid) else $error("message write missing");
   addr_size_a: assert property (msg_write.valid |->
      msg_write.addr64 == (msg_write.addr[63:32] != 32'h0)) else $error("address size");
   wake_gate_a: assert property (wake_message |-> $past(hotplug_request) &&
      $past(power_state_field) == 2'h3) else $error("wake message not allowed");
   sleep_block_a: assert property (hotplug_request && power_state_field == 2'h3 |=>
      !msg_write.valid) else $error("message write in sleep state");
endmodule : msi_pm_properties
bind msi_and_power_mgmt_regs msi_pm_properties msi_pm_properties_inst (.ref_clk(ref_clk),
   .rst(rst), .warm_rst(warm_rst), .hotplug_strap_config(hotplug_strap_config),
   .message_interrupt_enable(message_interrupt_enable), .cfg_req(cfg_req),
   .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .hotplug_request(hotplug_request),
   .msg_write(msg_write), .wake_message(wake_message), .power_state_field(power_state_field));

/* File: testbench/rc_model.sv */
// Root complex stand-in that collects interrupt writes and wake messages
`timescale 1ns/1ns
module rc_model (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire msi_pm_pkg::msg_write_t msg_write,
   input  wire logic                   wake_message,
   output int                          msi_cnt,
   output int                          pme_cnt,
   output msi_pm_pkg::msg_write_t      last_msg
);
   import msi_pm_pkg::*;
   // Count each arriving message and keep the last write
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         msi_cnt <= 0;
         pme_cnt <= 0;
      end else begin
         if (msg_write.valid) begin
            msi_cnt <= msi_cnt + 1;
            last_msg <= msg_write;
         end
         if (wake_message) pme_cnt <= pme_cnt + 1;
      end
   end
endmodule : rc_model

/* File: testbench/msi_and_power_mgmt_regs_bench.sv */
// Self-checking bench for the message and power register bank
`timescale 1ns/1ns
module msi_and_power_mgmt_regs_bench;
   import msi_pm_pkg::*;
   logic ref_clk = 0, rst = 1, warm_rst = 0, strap = 1, msi_en = 0, hp = 0;
   cfg_req_t    req = '0;    // Configuration request
   logic [31:0] rdata, lo, hi, d, v;
   logic        ack, wake;
   logic [1:0]  ps;
   msg_write_t  mw, last;
   int          msi_cnt, pme_cnt, error_cnt = 0, checked = 0, seed = 87207, n, k;
   logic [7:0]  offs [5] = '{8'h60, 8'h64, 8'h68, 8'h70, 8'h74};
   always #20 ref_clk = ~ref_clk;
   msi_and_power_mgmt_regs msi_and_power_mgmt_regs_inst (.ref_clk(ref_clk), .rst(rst),
      .warm_rst(warm_rst), .hotplug_strap_config(strap), .message_interrupt_enable(msi_en),
      .cfg_req(req), .cfg_rdata(rdata), .cfg_ack(ack), .hotplug_request(hp),
      .msg_write(mw), .wake_message(wake), .power_state_field(ps));
   rc_model rc_model_inst (.ref_clk(ref_clk), .rst(rst), .msg_write(mw),
      .wake_message(wake), .msi_cnt(msi_cnt), .pme_cnt(pme_cnt), .last_msg(last));
   // Expected capability word for a strap level
   function automatic logic [31:0] exp_cap(input logic s);
      return {16'hC802, s ? 8'h78 : 8'hD8, 8'h01};
   endfunction : exp_cap
   task cmp(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // One configuration access, answer taken with the ack
   task acc(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
      @(negedge ref_clk);
      req = {~w, w, a, be, wd};
      @(negedge ref_clk);
      cmp(ack, 1);
      v = rdata;
      req = '0;
   endtask : acc
   // One-cycle service request from the hot-plug side
   task pulse;
      @(negedge ref_clk);
      hp = 1;
      @(negedge ref_clk);
      hp = 0;
      @(negedge ref_clk);
   endtask : pulse
   task end_sim;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   initial begin
      #400000;
      error_cnt++;
      end_sim;
   end
   initial begin
      repeat (10) @(negedge ref_clk);
      rst = 0;
      repeat (2) @(negedge ref_clk);
      foreach (offs[i]) begin
         acc(0, offs[i], 0, 0);
         cmp(v, 0);
      end
      for (n = 1; n >= 0; n--) begin
         strap = n[0];
         repeat (2) @(negedge ref_clk);
         acc(0, 8'h6C, 0, 0);
         cmp(v, exp_cap(n[0]));
      end
      for (n = 0; n < 4; n++) begin
         lo = $random(seed);
         hi = (n == 3) ? 0 : $random(seed);
         d = $random(seed);
         acc(1, 8'h60, lo, 4'hF);
         acc(1, 8'h64, hi, 4'hF);
         acc(1, 8'h68, d, 4'hF);
         acc(0, 8'h60, 0, 0);
         cmp(v, lo & 32'hFFFFFFFC);
         acc(0, 8'h64, 0, 0);
         cmp(v, hi & 32'hFFFFFFFC);
         msi_en = n[0];
         k = msi_cnt;
         pulse;
         cmp(msi_cnt - k, n[0]);
         if (n[0]) begin
            cmp(last.addr, {hi[31:2], 2'h0, lo[31:2], 2'h0});
            cmp(last.addr64, hi != 0);
            cmp(last.data[15:0], d[15:0]);
         end
      end
      acc(1, 8'h70, 1, 4'h1);
      acc(1, 8'h70, 2, 4'h1);
      cmp(ps, 0);
      acc(1, 8'h70, 3, 4'h1);
      cmp(ps, 3);
      k = msi_cnt;
      pulse;
      acc(0, 8'h70, 0, 0);
      cmp(v, 32'h8003);
      cmp(msi_cnt - k + pme_cnt, 0);
      acc(1, 8'h70, 32'h0102, 4'h3);
      cmp(ps, 3);
      pulse;
      cmp(pme_cnt, 1);
      @(negedge ref_clk);
      warm_rst = 1;
      @(negedge ref_clk);
      warm_rst = 0;
      acc(0, 8'h70, 0, 0);
      cmp(v, 32'h8100);
      acc(1, 8'h70, 32'h8100, 4'h2);
      acc(0, 8'h70, 0, 0);
      cmp(v, 32'h0100);
      acc(1, 8'h74, 32'hFFFFFFFF, 4'hF);
      end_sim;
   end
endmodule : msi_and_power_mgmt_regs_bench
